/* core/ppmr_receiver.sv */
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
module ppmr_receiver #(
    parameter int CNT_W     = ppmr_pkg::CNT_WIDTH,
    parameter int T1_CYCLES = ppmr_pkg::T1_BASE_CYCLES,
    parameter int T0_CYCLES = ppmr_pkg::T0_BASE_CYCLES,
    parameter int TS_CYCLES = ppmr_pkg::TS_BASE_CYCLES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ppm_in,
    input  wire logic        rate_a,
    input  wire logic        rate_b,
    input  wire logic        hold_mode_select,
    input  wire logic        code_drive_enable_n,
    output logic      [4:0]  code_out,
    output logic             code_oe,
    output logic             data_ready_n,
    output logic             irq
);

    localparam int CB = ppmr_pkg::CODE_BITS;

    // ========================================================
    // pin synchronisers
    logic [ppmr_pkg::SYNC_WIDTH-1:0] pins_s;
    logic ppm_s, rate_a_s, rate_b_s, hold_s, oen_s;

    ppmr_sync #(
        .W         (ppmr_pkg::SYNC_WIDTH),
        .RESET_VAL (ppmr_pkg::SYNC_RESET)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({code_drive_enable_n, hold_mode_select, rate_b, rate_a, ppm_in}),
        .sync_out (pins_s)
    );

    assign ppm_s    = pins_s[0];
    assign rate_a_s = pins_s[1];
    assign rate_b_s = pins_s[2];
    assign hold_s   = pins_s[3];
    assign oen_s    = pins_s[4];

    // ========================================================
    // rate selection and interval windows
    logic [1:0]       rate_code, sh;
    logic             rate_ok;
    logic [CNT_W-1:0] t1, t0, ts, one_lo, one_hi, zero_lo, zero_hi, gap_lo, drop_limit;

    assign rate_code = {rate_b_s, rate_a_s};

    always_comb begin
        rate_ok = 1'b1;
        sh      = ppmr_pkg::SHIFT_FAST;
        unique case (rate_code)
            ppmr_pkg::RATE_SLOW: sh = ppmr_pkg::SHIFT_SLOW;
            ppmr_pkg::RATE_MID:  sh = ppmr_pkg::SHIFT_MID;
            ppmr_pkg::RATE_FAST: sh = ppmr_pkg::SHIFT_FAST;
            ppmr_pkg::RATE_NONE: rate_ok = 1'b0;
        endcase
    end

    // a window of plus or minus one eighth absorbs resonator mismatch but
    // keeps the neighbouring rates' bit spacings outside it
    assign t1         = CNT_W'(T1_CYCLES) << sh;
    assign t0         = CNT_W'(T0_CYCLES) << sh;
    assign ts         = CNT_W'(TS_CYCLES) << sh;
    assign one_lo     = t1 - (t1 >> ppmr_pkg::TOL_SHIFT);
    assign one_hi     = t1 + (t1 >> ppmr_pkg::TOL_SHIFT);
    assign zero_lo    = t0 - (t0 >> ppmr_pkg::TOL_SHIFT);
    assign zero_hi    = t0 + (t0 >> ppmr_pkg::TOL_SHIFT);
    assign gap_lo     = ts - (ts >> ppmr_pkg::TOL_SHIFT);
    assign drop_limit = ts << ppmr_pkg::DROP_GAP_SHIFT;

    // ========================================================
    // pulse spacing counter
    logic             ppm_prev, rise;
    logic [CNT_W-1:0] cnt;
    logic             is_one, is_zero, is_gap;

    // only rising edges are timed, so pulse width never matters
    assign rise = ppm_s & ~ppm_prev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ppm_prev <= 1'b0;
            cnt      <= '0;
        end else begin
            ppm_prev <= ppm_s;
            if (rise) begin
                cnt <= '0;
            end else if (cnt != '1) begin
                cnt <= cnt + 1'b1;
            end
        end
    end

    assign is_one  = (cnt >= one_lo) && (cnt <= one_hi);
    assign is_zero = (cnt >= zero_lo) && (cnt <= zero_hi);
    assign is_gap  = (cnt >= gap_lo);

    // ========================================================
    // word assembly
    logic                    ctrl_enable, run;
    ppmr_pkg::ppmr_state_type state;
    logic [2:0]              bits;
    logic [CB-1:0]           shift, next_word, prev_word;
    logic                    have_prev, word_done, word_bad, match;

    assign run       = ctrl_enable & rate_ok;
    assign next_word = {shift[CB-2:0], is_one};
    assign word_done = run && rise && (state == ppmr_pkg::PPMR_COLLECT) &&
                       (is_one || is_zero) && (bits == 3'(CB - 1));
    assign word_bad  = run && (state == ppmr_pkg::PPMR_COLLECT) &&
                       ((rise && !is_one && !is_zero) || (!rise && cnt > zero_hi));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ppmr_pkg::PPMR_HUNT;
            bits  <= '0;
            shift <= '0;
        end else if (!run) begin
            state <= ppmr_pkg::PPMR_HUNT;
            bits  <= '0;
        end else if (rise) begin
            unique case (state)
                ppmr_pkg::PPMR_HUNT: begin
                    if (is_gap) begin
                        state <= ppmr_pkg::PPMR_COLLECT;
                        bits  <= '0;
                    end
                end
                ppmr_pkg::PPMR_COLLECT: begin
                    if (is_one || is_zero) begin
                        shift <= next_word;
                        bits  <= bits + 1'b1;
                        if (bits == 3'(CB - 1)) begin
                            state <= ppmr_pkg::PPMR_HUNT;
                        end
                    end else if (is_gap) begin
                        bits <= '0;
                    end else begin
                        state <= ppmr_pkg::PPMR_HUNT;
                    end
                end
            endcase
        end else if (state == ppmr_pkg::PPMR_COLLECT && cnt > zero_hi) begin
            state <= ppmr_pkg::PPMR_HUNT;
        end
    end

    // a bad word breaks the pair, so the two matching words are consecutive
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            have_prev <= 1'b0;
            prev_word <= '0;
        end else if (!run) begin
            have_prev <= 1'b0;
        end else if (word_done) begin
            have_prev <= 1'b1;
            prev_word <= next_word;
        end else if (word_bad) begin
            have_prev <= 1'b0;
        end
    end

    assign match = word_done && have_prev && (prev_word == next_word);

    // ========================================================
    // code register, strobe and drive
    logic             code_valid, new_code, drop;
    logic [CNT_W-1:0] drop_cnt;

    assign new_code = match && (!code_valid || code_out != next_word);
    assign drop     = code_valid && hold_s && !match && (drop_cnt >= drop_limit - 1'b1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            code_out     <= '0;
            code_valid   <= 1'b0;
            data_ready_n <= 1'b1;
        end else begin
            if (new_code) begin
                code_out   <= next_word;
                code_valid <= 1'b1;
            end else if (drop) begin
                code_out   <= '0;
                code_valid <= 1'b0;
            end
            // strobe goes low one cycle after the code lands
            data_ready_n <= (new_code || drop) ? 1'b1 : !code_valid;
        end
    end

    // in latched mode the timer stays cleared and the code is kept
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drop_cnt <= '0;
        end else if (!code_valid || !hold_s || match) begin
            drop_cnt <= '0;
        end else if (drop_cnt != '1) begin
            drop_cnt <= drop_cnt + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            code_oe <= 1'b0;
        end else begin
            code_oe <= !oen_s;
        end
    end

    // ========================================================
    // APB slave: zero wait states, data and error registered in setup
    logic                           setup, wr, hit;
    logic [ppmr_pkg::IRQ_WIDTH-1:0] irq_status, irq_mask, irq_set;
    logic [31:0]                    rd_mux;

    assign setup = psel && !penable;
    assign wr    = psel && penable && pready && pwrite;
    assign hit   = (paddr == ppmr_pkg::ADDR_CTRL) || (paddr == ppmr_pkg::ADDR_STATUS) ||
                   (paddr == ppmr_pkg::ADDR_IRQ_STATUS) || (paddr == ppmr_pkg::ADDR_IRQ_MASK);

    always_comb begin
        rd_mux = 32'h00000000;
        unique case (paddr)
            ppmr_pkg::ADDR_CTRL:       rd_mux[ppmr_pkg::CTRL_ENABLE_BIT] = ctrl_enable;
            ppmr_pkg::ADDR_STATUS: begin
                rd_mux[ppmr_pkg::STATUS_CODE_LSB +: CB] = code_out;
                rd_mux[ppmr_pkg::STATUS_VALID_BIT]      = code_valid;
                rd_mux[ppmr_pkg::STATUS_RATE_LSB +: 2]  = rate_code;
            end
            ppmr_pkg::ADDR_IRQ_STATUS: rd_mux[ppmr_pkg::IRQ_WIDTH-1:0] = irq_status;
            ppmr_pkg::ADDR_IRQ_MASK:   rd_mux[ppmr_pkg::IRQ_WIDTH-1:0] = irq_mask;
            default:                   rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready <= setup;
            if (setup) begin
                pslverr <= !hit;
                prdata  <= pwrite ? 32'h00000000 : rd_mux;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_enable <= ppmr_pkg::CTRL_RESET[ppmr_pkg::CTRL_ENABLE_BIT];
            irq_mask    <= ppmr_pkg::IRQ_MASK_RESET;
        end else if (wr && paddr == ppmr_pkg::ADDR_CTRL) begin
            ctrl_enable <= pwdata[ppmr_pkg::CTRL_ENABLE_BIT];
        end else if (wr && paddr == ppmr_pkg::ADDR_IRQ_MASK) begin
            irq_mask <= pwdata[ppmr_pkg::IRQ_WIDTH-1:0];
        end
    end

    // ========================================================
    // interrupts: a new event wins over a write-one clear
    always_comb begin
        irq_set                        = '0;
        irq_set[ppmr_pkg::IRQ_NEW_BIT]  = new_code;
        irq_set[ppmr_pkg::IRQ_DROP_BIT] = drop;
        irq_set[ppmr_pkg::IRQ_BAD_BIT]  = word_bad;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= '0;
            irq         <= 1'b0;
        end else begin
            if (wr && paddr == ppmr_pkg::ADDR_IRQ_STATUS) begin
                irq_status <= (irq_status & ~pwdata[ppmr_pkg::IRQ_WIDTH-1:0]) | irq_set;
            end else begin
                irq_status <= irq_status | irq_set;
            end
            irq <= |(irq_status & irq_mask);
        end
    end

    // ========================================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ready_settle_a: assert property (new_code |=> data_ready_n ##1 (!data_ready_n || !code_valid))
        else $error("strobe did not follow code update by one cycle");
    update_pair_a: assert property ($changed(code_out) && code_valid |-> $past(match))
        else $error("code changed without a matching word pair");
    latched_keep_a: assert property (code_valid && !hold_s && !new_code |=> code_valid && $stable(code_out))
        else $error("latched code lost");
    momentary_drop_a: assert property (drop |=> !code_valid && data_ready_n && code_out == '0)
        else $error("momentary drop incomplete");
    drive_on_a: assert property (!oen_s |=> code_oe)
        else $error("code outputs not driven");
    drive_off_a: assert property (oen_s |=> !code_oe)
        else $error("code outputs not floated");
    strobe_idle_a: assert property (!code_valid |-> data_ready_n)
        else $error("strobe low without valid code");
    rate_invalid_a: assert property (!run |=> state == ppmr_pkg::PPMR_HUNT && !have_prev)
        else $error("decoding while rate invalid or disabled");
    rate_ratio_a: assert property (rate_ok |-> int'(ts) == 3 * int'(t1) && 2 * int'(t0) == 3 * int'(t1))
        else $error("interval ratios wrong");
    slow_rate_a: assert property (rate_code == ppmr_pkg::RATE_SLOW |-> int'(t1) == 4 * T1_CYCLES)
        else $error("slow rate timing wrong");
    mid_rate_a: assert property (rate_code == ppmr_pkg::RATE_MID |-> int'(t1) == 2 * T1_CYCLES)
        else $error("mid rate timing wrong");
    edge_only_a: assert property (word_done |-> rise && (is_one || is_zero))
        else $error("word completed off a pulse position");

    new_code_c:  cover property (new_code);
    drop_c:      cover property (drop);
    bad_word_c:  cover property (word_bad);
    repeat_c:    cover property (match && !new_code);

endmodule

/* core/ppmr_pkg.sv */
package ppmr_pkg;

    // ========================================================
    // register map
    localparam logic [7:0] ADDR_CTRL       = 8'h00;
    localparam logic [7:0] ADDR_STATUS     = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK   = 8'h0C;

    // ========================================================
    // field positions and reset values
    localparam int          CTRL_ENABLE_BIT  = 0;
    localparam logic [31:0] CTRL_RESET       = 32'h00000001;
    localparam int          STATUS_CODE_LSB  = 0;
    localparam int          STATUS_VALID_BIT = 8;
    localparam int          STATUS_RATE_LSB  = 10;
    localparam int          IRQ_NEW_BIT      = 0;
    localparam int          IRQ_DROP_BIT     = 1;
    localparam int          IRQ_BAD_BIT      = 2;
    localparam int          IRQ_WIDTH        = 3;
    localparam logic [2:0]  IRQ_MASK_RESET   = 3'h0;

    // ========================================================
    // word format and timing, in oscillator cycles at the fastest rate
    localparam int CODE_BITS       = 5;
    localparam int CNT_WIDTH       = 18;
    localparam int T1_BASE_CYCLES  = 1024;
    localparam int T0_BASE_CYCLES  = 1536;
    localparam int TS_BASE_CYCLES  = 3072;
    localparam int TOL_SHIFT       = 3;
    localparam int DROP_GAP_SHIFT  = 2;
    localparam int SYNC_WIDTH      = 5;
    localparam logic [4:0] SYNC_RESET = 5'h10;

    // ========================================================
    // rate-select codes {b, a} and the shift applied to the base timing
    localparam logic [1:0] RATE_NONE = 2'h0;
    localparam logic [1:0] RATE_SLOW = 2'h1;
    localparam logic [1:0] RATE_MID  = 2'h2;
    localparam logic [1:0] RATE_FAST = 2'h3;
    localparam logic [1:0] SHIFT_SLOW = 2'h2;
    localparam logic [1:0] SHIFT_MID  = 2'h1;
    localparam logic [1:0] SHIFT_FAST = 2'h0;

    typedef enum logic [0:0] {
        PPMR_HUNT,
        PPMR_COLLECT
    } ppmr_state_type;

endpackage

/* core/ppmr_sync.sv */
`timescale 1ns/1ps
module ppmr_sync #(
    parameter int               W         = 1,
    parameter logic [W-1:0]     RESET_VAL = '0
) (
    input  wire logic           pclk,
    input  wire logic           presetn,
    input  wire logic [W-1:0]   async_in,
    output logic      [W-1:0]   sync_out
);

    logic [W-1:0] stage1;

    // stage1 feeds only sync_out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1   <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule

/* tb/ppmr_tx_model.sv */
`timescale 1ns/1ps
// ==========================================================
// far-side transmitter: marker rise, then per word a gap and five bit rises
module ppmr_tx_model #(
    parameter int T1 = 16,
    parameter int T0 = 24,
    parameter int TS = 48
) (
    input  wire logic       pclk,
    input  wire logic       start,
    input  wire logic [4:0] code,
    input  wire logic [1:0] rate,
    input  wire logic [2:0] words,
    input  wire logic [2:0] width,
    output logic            ppm,
    output logic            busy
);
    int sh;

    initial begin
        ppm = 1'b0;
        busy = 1'b0;
    end

    // rise now, then hold the spacing to the next rise; width stays >= 1 cycle
    task automatic pulse(input int sp);
        ppm <= 1'b1;
        repeat (width) @(posedge pclk);
        ppm <= 1'b0;
        repeat (sp - width) @(posedge pclk);
    endtask

    always @(posedge pclk) begin
        if (start) begin
            busy <= 1'b1;
            sh = 3 - rate;
            for (int w = 0; w < words; w++) begin
                pulse(TS << sh);
                for (int i = 4; i >= 0; i--) begin
                    pulse((code[i] ? T1 : T0) << sh);
                end
            end
            // closing rise ends the fifth bit of the last word
            ppm <= 1'b1;
            repeat (width) @(posedge pclk);
            ppm <= 1'b0;
            busy <= 1'b0;
        end
    end
endmodule

/* tb/ppmr_testbench.sv */
`timescale 1ns/1ps
module testbench;
    logic        pclk, presetn, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, ppm_in, rate_a, rate_b, hold, en_n;
    logic [4:0]  code_out;
    logic        code_oe, data_ready_n, irq;
    logic        tx_start, tx_busy;
    logic [4:0]  tx_code;
    logic [1:0]  tx_rate;
    logic [2:0]  tx_words, tx_width;
    logic [4:0]  host_code;
    int          error_cnt, n_checks;
    wire  [4:0]  code_pins = code_oe ? code_out : {5{1'bz}};

    ppmr_receiver #(.T1_CYCLES(16), .T0_CYCLES(24), .TS_CYCLES(48)) i_dut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ppm_in(ppm_in), .rate_a(rate_a), .rate_b(rate_b),
        .hold_mode_select(hold), .code_drive_enable_n(en_n), .code_out(code_out),
        .code_oe(code_oe), .data_ready_n(data_ready_n), .irq(irq));

    // the model's default spacings already match the receiver's small bases
    ppmr_tx_model i_tx (
        .pclk(pclk), .start(tx_start), .code(tx_code), .rate(tx_rate),
        .words(tx_words), .width(tx_width), .ppm(ppm_in), .busy(tx_busy));

    always #2 pclk = ~pclk;

    // host side: latch the pins while the strobe is low
    always @(posedge pclk) begin
        if (!data_ready_n) host_code <= code_pins;
    end

    // ==========================================================
    // shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic test_done;
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= wr;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        if (n >= 50) error_cnt++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic send(input logic [4:0] c, input logic [2:0] nw, input logic [1:0] r,
                        input logic [2:0] w);
        int n;
        @(posedge pclk);
        tx_code <= c;
        tx_words <= nw;
        tx_rate <= r;
        tx_width <= w;
        tx_start <= 1'b1;
        @(posedge pclk);
        tx_start <= 1'b0;
        repeat (2) @(posedge pclk);
        n = 0;
        while (tx_busy !== 1'b0 && n < 20000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 20000) error_cnt++;
        repeat (6) @(posedge pclk);
    endtask

    task automatic set_rate(input logic [1:0] r);
        @(posedge pclk);
        {rate_b, rate_a} <= r;
        repeat (8) @(posedge pclk);
    endtask

    task automatic chk_code(input logic [4:0] c);
        chk(code_out, c);
        chk(data_ready_n, 1'b0);
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset;
        chk({code_out, data_ready_n, irq}, 7'h02);
        apb(1'b0, ppmr_pkg::ADDR_CTRL, 32'h0);
        chk(rd, ppmr_pkg::CTRL_RESET);
        apb(1'b0, ppmr_pkg::ADDR_IRQ_MASK, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk(pslverr, 1'b1);
        chk(rd, 32'h0);
    endtask

    // each rate pairs only after two words; pulse width differs per rate
    task automatic t_rates;
        for (int r = 1; r <= 3; r++) begin
            set_rate(r[1:0]);
            send(5'h0A + r[4:0], 3'h1, r[1:0], 3'(2 * r - 1));
            chk(code_out === 5'h0A + r[4:0], 1'b0);
            send(5'h0A + r[4:0], 3'h2, r[1:0], 3'(2 * r - 1));
            chk_code(5'h0A + r[4:0]);
        end
    endtask

    task automatic t_codes;
        for (int c = 0; c < 32; c++) begin
            send(c[4:0], 3'h2, 2'h3, 3'h1);
            chk_code(c[4:0]);
        end
    endtask

    task automatic t_foreign;
        send(5'h15, 3'h2, 2'h1, 3'h2);
        chk(code_out, 5'h1F);
        set_rate(2'h0);
        send(5'h15, 3'h2, 2'h3, 3'h2);
        chk(code_out, 5'h1F);
        set_rate(2'h3);
    endtask

    task automatic t_latched;
        send(5'h09, 3'h2, 2'h3, 3'h1);
        repeat (1000) @(posedge pclk);
        chk_code(5'h09);
        chk(host_code, 5'h09);
    endtask

    // momentary drop also checks the drop interrupt and its clear
    task automatic t_momentary;
        apb(1'b1, ppmr_pkg::ADDR_IRQ_MASK, 32'h2);
        apb(1'b1, ppmr_pkg::ADDR_IRQ_STATUS, 32'h7);
        @(posedge pclk);
        hold <= 1'b1;
        send(5'h13, 3'h2, 2'h3, 3'h1);
        chk_code(5'h13);
        apb(1'b0, ppmr_pkg::ADDR_STATUS, 32'h0);
        chk(rd[8:0], 9'h113);
        apb(1'b0, ppmr_pkg::ADDR_IRQ_STATUS, 32'h0);
        chk(rd[ppmr_pkg::IRQ_NEW_BIT], 1'b1);
        repeat (300) @(posedge pclk);
        chk({code_out, data_ready_n, irq}, 7'h03);
        apb(1'b1, ppmr_pkg::ADDR_IRQ_STATUS, 32'h2);
        repeat (3) @(posedge pclk);
        chk(irq, 1'b0);
        hold <= 1'b0;
    endtask

    task automatic t_drive;
        send(5'h16, 3'h2, 2'h3, 3'h1);
        en_n <= 1'b1;
        repeat (5) @(posedge pclk);
        chk(code_pins, {5{1'bz}});
        en_n <= 1'b0;
        repeat (5) @(posedge pclk);
        chk(code_pins, 5'h16);
    endtask

    task automatic t_clear;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({code_out, data_ready_n, code_oe}, 7'h02);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask

    // ==========================================================
    // main sequence and watchdog
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        rate_a = 1'b1;
        rate_b = 1'b1;
        hold = 1'b0;
        en_n = 1'b0;
        tx_start = 1'b0;
        tx_code = 5'h00;
        tx_rate = 2'h3;
        tx_words = 3'h0;
        tx_width = 3'h1;
        error_cnt = 0;
        n_checks = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset;
        t_rates;
        t_codes;
        t_foreign;
        t_latched;
        t_momentary;
        t_drive;
        t_clear;
        test_done;
    end

    // the whole run needs well under half of this span
    initial begin
        repeat (90000) @(posedge pclk);
        error_cnt++;
        test_done;
    end
endmodule
